// ===== src/smc_consts.svh
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// command and reply codes
`define SMC_CMD_WDOG 8'h1D
`define SMC_CMD_DBG 8'h1E
`define SMC_CMD_TEXT 8'h1F
`define SMC_CMD_BAUD 8'h21
`define SMC_CMD_GPSET 8'h22
`define SMC_CMD_GPRD 8'h23
`define SMC_RSP_FLAG 8'h40
`define SMC_DBG_LEN 4'hF
`define SMC_GPRD_LEN 4'h4
// limits
`define SMC_NPIN 5
`define SMC_COL_MAX 8'h0F
`define SMC_ROW_MAX 8'h01
`define SMC_TXT_MIN 5'h03
`define SMC_TXT_MAX 5'h12
`define SMC_VAL_HIGH 8'h64
`define SMC_CFG_MAX 8'h0F
`define SMC_BAUD_NUM 8'h02
`define SMC_BAUD_RST 8'h01
// reset pin configuration, one nibble per pin, pin 0 lowest
`define SMC_GPCFG_RST 20'h22232
`define SMC_HOSTRST_PIN 3
// timing
`define SMC_CLK_HZ 50000000
`define SMC_HOSTRST_S 1
`define SMC_PWM_HZ 100
`define SMC_PWM_STEPS 100
`define SMC_SAMPLE_HZ 32
`endif

// ===== src/smc_pkg.sv
package smc_pkg;
   typedef logic [7:0] smc_byte_t;
   typedef enum logic [2:0] {
      DRV_UP_PD = 3'h0,
      DRV_STRONG = 3'h1,
      DRV_HIZ = 3'h2,
      DRV_PU_DN = 3'h3,
      DRV_SUP_Z = 3'h4,
      DRV_SLOW = 3'h5,
      DRV_RSVD = 3'h6,
      DRV_Z_SDN = 3'h7
   } smc_drv_t;
endpackage

// ===== src/smc_cmd_core.sv
// Functional notes
// [RULE1] watchdog command with timeout zero disables the watchdog
// [RULE2] host must resend watchdog command before timeout seconds elapse
// [RULE3] watchdog expiry pulses the host reset line
// [RULE4] watchdog is off after power-up
// [RULE5] accepted command answered with type ORed 0x40, watchdog reply empty
// [RULE6] empty debug request answered with type 0x5E and 15 bytes
// [RULE7] status bytes 0 and 12 zero, others masks, counter, sense select
// [RULE8] text command has column, row and 1 to 16 characters
// [RULE9] baud acknowledge sent at old rate, then rate switches
// [RULE10] host switches its rate only after the acknowledge
// [RULE11] link starts at 19200 baud after reset
// [RULE12] five pins, index 5 and above refused
// [RULE13] two bytes set value only, three also set function and drive
// [RULE14] value 0 low, 100 high, 1 to 99 PWM at 100 Hz
// [RULE15] three-bit drive mode, 010 high impedance, 110 refused
// [RULE16] configuration byte 0 to 15, bit 3 function, bits 2..0 drive
// [RULE17] function 1 user control, 0 shared default function
// [RULE18] every pin sampled at 32 Hz, last level kept
// [RULE19] rising and falling edges between samples recorded per pin
// [RULE20] pin read reports level and edge flags, then clears the flags
// [RULE21] host reset drives the reset pin for one second then releases
// [RULE22] counter loaded per command, decremented per second, fires at zero
// [RULE23] bad parameter or length changes nothing and gets no acknowledge
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_cmd_core
   import smc_pkg::*;
#(
   parameter int NPIN = `SMC_NPIN,
   parameter int SEC_CYC = `SMC_CLK_HZ,
   parameter int HOSTRST_CYC = `SMC_CLK_HZ * `SMC_HOSTRST_S,
   parameter int PWM_STEP_CYC = `SMC_CLK_HZ / (`SMC_PWM_HZ * `SMC_PWM_STEPS),
   parameter int SAMPLE_CYC = `SMC_CLK_HZ / `SMC_SAMPLE_HZ
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // command
   input wire logic cmdValid,
   input wire logic [7:0] cmdType,
   input wire logic [4:0] cmdLen,
   input wire logic [143:0] cmdData,
   output logic cmdErr,
   // reply
   output logic rspValid,
   output logic [7:0] rspType,
   output logic [3:0] rspLen,
   output logic [119:0] rspData,
   input wire logic rspSent,
   // text placement
   output logic txtValid,
   output logic [3:0] txtCol,
   output logic txtRow,
   output logic [4:0] txtCnt,
   output logic [127:0] txtData,
   // baud rate
   output logic [7:0] baudCode,
   // status sources
   input wire logic [31:0] tempMask,
   input wire logic [7:0] keyPressMask,
   input wire logic [7:0] keyRelMask,
   input wire logic [7:0] atxFunc,
   input wire logic [7:0] contrast,
   input wire logic [7:0] keyLight,
   input wire logic [7:0] senseSel,
   input wire logic [7:0] lcdContrast,
   input wire logic [7:0] lcdLight,
   // watchdog and host reset
   input wire logic rstActLevel,
   output logic wdActive,
   output logic hostRstAct,
   // pins
   input wire logic [NPIN-1:0] gpioIn,
   input wire logic [NPIN-1:0] altOut,
   input wire logic [NPIN-1:0] altOe,
   output logic [NPIN-1:0] gpioOut,
   output logic [NPIN-1:0] gpioOe,
   output logic [NPIN-1:0] gpioPu,
   output logic [NPIN-1:0] gpioPd,
   output logic [NPIN-1:0] gpioSlow
);
   logic [7:0] b0, b1, b2;
   logic wdCmd, dbgCmd, txtCmd, baudCmd, gpCmd, rdCmd, cmdOk, go;
   logic wdEn_r, secTick, pwmTick, smpTick, wdFire;
   logic [7:0] wdCnt_r, baudNew_r;
   logic baudPend_r;
   logic [31:0] secCnt_r, rstCnt_r, pwmCnt_r, smpCnt_r;
   logic [6:0] phase_r;
   logic [7:0] gpVal_r [NPIN];
   logic [3:0] gpCfg_r [NPIN];
   logic [NPIN-1:0] s1_r, s2_r, smp_r, rise_r, fall_r, lvl, rdHit;

   assign b0 = cmdData[7:0];
   assign b1 = cmdData[15:8];
   assign b2 = cmdData[23:16];
   assign wdCmd = cmdType == `SMC_CMD_WDOG && cmdLen == 5'h01;
   assign dbgCmd = cmdType == `SMC_CMD_DBG && cmdLen == 5'h00; // RULE6
   assign txtCmd = cmdType == `SMC_CMD_TEXT && cmdLen >= `SMC_TXT_MIN && cmdLen <= `SMC_TXT_MAX
      && b0 <= `SMC_COL_MAX && b1 <= `SMC_ROW_MAX; // RULE8
   assign baudCmd = cmdType == `SMC_CMD_BAUD && cmdLen == 5'h01 && b0 < `SMC_BAUD_NUM;
   assign gpCmd = cmdType == `SMC_CMD_GPSET && (cmdLen == 5'h02 || cmdLen == 5'h03)
      && b0 < 8'(NPIN) && b1 <= `SMC_VAL_HIGH // RULE12 RULE14
      && (cmdLen == 5'h02 || (b2 <= `SMC_CFG_MAX && b2[2:0] != DRV_RSVD)); // RULE15 RULE16
   assign rdCmd = cmdType == `SMC_CMD_GPRD && cmdLen == 5'h01 && b0 < 8'(NPIN); // RULE12
   assign cmdOk = wdCmd | dbgCmd | txtCmd | baudCmd | gpCmd | rdCmd;
   assign go = ce && cmdValid && cmdOk; // RULE23
   assign secTick = secCnt_r == 32'(SEC_CYC - 1);
   assign wdFire = wdEn_r && secTick && wdCnt_r == 8'h01 && !(cmdValid && wdCmd);
   assign wdActive = wdEn_r;
   assign hostRstAct = rstCnt_r != 32'h0;

   // reply and error pulses
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rspValid <= 1'b0;
         rspType <= 8'h00;
         rspLen <= 4'h0;
         rspData <= 120'h0;
         cmdErr <= 1'b0;
      end
      else if (ce)
      begin
         rspValid <= go; // RULE5
         cmdErr <= cmdValid && !cmdOk; // RULE23
         if (go)
         begin
            rspType <= cmdType | `SMC_RSP_FLAG; // RULE5
            rspLen <= 4'h0;
            rspData <= 120'h0;
            if (dbgCmd)
            begin
               rspLen <= `SMC_DBG_LEN; // RULE6
               rspData <= {lcdLight, lcdContrast, 8'h00, senseSel, keyLight, contrast, wdCnt_r,
                  atxFunc, keyRelMask, keyPressMask, tempMask, 8'h00}; // RULE7
            end
            if (rdCmd)
            begin
               rspLen <= `SMC_GPRD_LEN; // RULE20
               rspData <= {88'h0, 4'h0, gpCfg_r[b0[2:0]], gpVal_r[b0[2:0]],
                  5'h00, rise_r[b0[2:0]], fall_r[b0[2:0]], smp_r[b0[2:0]], b0};
            end
         end
      end
   end

   // text placement
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         txtValid <= 1'b0;
         txtCol <= 4'h0;
         txtRow <= 1'b0;
         txtCnt <= 5'h00;
         txtData <= 128'h0;
      end
      else if (ce)
      begin
         txtValid <= go && txtCmd; // RULE8
         if (go && txtCmd)
         begin
            txtCol <= b0[3:0];
            txtRow <= b1[0];
            txtCnt <= cmdLen - 5'h02;
            txtData <= cmdData[143:16];
         end
      end
   end

   // baud rate: new code waits for the acknowledge to leave at the old rate
   logic [7:0] baud_r;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         baud_r <= `SMC_BAUD_RST; // RULE11
         baudNew_r <= `SMC_BAUD_RST;
         baudPend_r <= 1'b0;
      end
      else if (ce)
      begin
         if (go && baudCmd)
         begin
            baudNew_r <= b0;
            baudPend_r <= 1'b1;
         end
         else if (baudPend_r && rspSent)
         begin
            baud_r <= baudNew_r; // RULE9
            baudPend_r <= 1'b0;
         end
      end
   end
   assign baudCode = baud_r;

   // watchdog; the second prescaler restarts on every feed
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdEn_r <= 1'b0; // RULE4
         wdCnt_r <= 8'h00;
         secCnt_r <= 32'h0;
      end
      else if (ce)
      begin
         secCnt_r <= secTick ? 32'h0 : secCnt_r + 32'h1;
         if (go && wdCmd)
         begin
            wdCnt_r <= b0; // RULE22
            wdEn_r <= b0 != 8'h00; // RULE1
            secCnt_r <= 32'h0;
         end
         else if (wdEn_r && secTick)
         begin
            wdCnt_r <= wdCnt_r - 8'h01; // RULE22
            if (wdCnt_r == 8'h01)
               wdEn_r <= 1'b0; // RULE3
         end
      end
   end

   // host reset pulse
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rstCnt_r <= 32'h0;
      else if (ce)
      begin
         if (wdFire)
            rstCnt_r <= 32'(HOSTRST_CYC); // RULE3 RULE21
         else if (hostRstAct)
            rstCnt_r <= rstCnt_r - 32'h1;
      end
   end

   // pin configuration
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NPIN; i++)
         begin
            gpVal_r[i] <= 8'h00;
            gpCfg_r[i] <= 4'(`SMC_GPCFG_RST >> (4 * i));
         end
      end
      else if (go && gpCmd)
      begin
         gpVal_r[b0[2:0]] <= b1; // RULE13
         if (cmdLen == 5'h03)
            gpCfg_r[b0[2:0]] <= b2[3:0]; // RULE13 RULE16
      end
   end

   // 100 Hz PWM, one shared phase counter
   assign pwmTick = pwmCnt_r == 32'(PWM_STEP_CYC - 1);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pwmCnt_r <= 32'h0;
         phase_r <= 7'h00;
      end
      else if (ce)
      begin
         pwmCnt_r <= pwmTick ? 32'h0 : pwmCnt_r + 32'h1;
         if (pwmTick)
            phase_r <= phase_r == 7'(`SMC_PWM_STEPS - 1) ? 7'h00 : phase_r + 7'h01; // RULE14
      end
   end

   // pin driver decode
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         lvl[i] = gpVal_r[i] > {1'b0, phase_r}; // RULE14
         gpioOut[i] = 1'b0;
         gpioOe[i] = 1'b0;
         gpioPu[i] = 1'b0;
         gpioPd[i] = 1'b0;
         gpioSlow[i] = 1'b0;
         if (gpCfg_r[i][3])
         begin
            case (smc_drv_t'(gpCfg_r[i][2:0])) // RULE15 RULE17
               DRV_UP_PD:
               begin
                  gpioOe[i] = lvl[i];
                  gpioOut[i] = 1'b1;
                  gpioPd[i] = !lvl[i];
               end
               DRV_STRONG:
               begin
                  gpioOe[i] = 1'b1;
                  gpioOut[i] = lvl[i];
               end
               DRV_PU_DN:
               begin
                  gpioOe[i] = !lvl[i];
                  gpioPu[i] = lvl[i];
               end
               DRV_SUP_Z:
               begin
                  gpioOe[i] = lvl[i];
                  gpioOut[i] = 1'b1;
                  gpioSlow[i] = 1'b1;
               end
               DRV_SLOW:
               begin
                  gpioOe[i] = 1'b1;
                  gpioOut[i] = lvl[i];
                  gpioSlow[i] = 1'b1;
               end
               DRV_Z_SDN:
               begin
                  gpioOe[i] = !lvl[i];
                  gpioSlow[i] = 1'b1;
               end
               default:
                  gpioOe[i] = 1'b0;
            endcase
         end
         else if (i == `SMC_HOSTRST_PIN)
         begin
            gpioOe[i] = hostRstAct; // RULE17 RULE21
            gpioOut[i] = rstActLevel;
         end
         else
         begin
            gpioOe[i] = altOe[i]; // RULE17
            gpioOut[i] = altOut[i];
         end
      end
   end

   // 32 Hz sampling and edge tracking; a new edge wins over a read clear
   assign smpTick = smpCnt_r == 32'(SAMPLE_CYC - 1);
   always_comb
   begin
      rdHit = '0;
      if (go && rdCmd)
         rdHit[b0[2:0]] = 1'b1;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= '0;
         s2_r <= '0;
         smp_r <= '0;
         rise_r <= '0;
         fall_r <= '0;
         smpCnt_r <= 32'h0;
      end
      else if (ce)
      begin
         s1_r <= gpioIn;
         s2_r <= s1_r;
         smpCnt_r <= smpTick ? 32'h0 : smpCnt_r + 32'h1;
         if (smpTick)
            smp_r <= s2_r; // RULE18
         rise_r <= (rise_r & ~rdHit) | ({NPIN{smpTick}} & s2_r & ~smp_r); // RULE19 RULE20
         fall_r <= (fall_r & ~rdHit) | ({NPIN{smpTick}} & ~s2_r & smp_r); // RULE19 RULE20
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_wd_zero_off: assert property (go && wdCmd && b0 == 8'h00 |=> !wdEn_r && wdCnt_r == 8'h00) // RULE1
      else $error("watchdog not disabled by zero timeout");
   a_wd_fire_pulse: assert property (ce && wdFire |=> hostRstAct && !wdEn_r ##1 hostRstAct) // RULE3
      else $error("watchdog expiry did not start host reset");
   a_wd_decrement: assert property (ce && wdEn_r && secTick && !(cmdValid && wdCmd)
      |=> wdCnt_r == $past(wdCnt_r) - 8'h01) // RULE22
      else $error("watchdog counter not decremented");
   a_ack_type: assert property (go |=> rspValid && rspType == ($past(cmdType) | 8'h40)) // RULE5
      else $error("acknowledge type wrong");
   a_dbg_reply: assert property (go && dbgCmd |=> rspLen == 4'hF && rspData[7:0] == 8'h00
      && rspData[103:96] == 8'h00 && rspData[71:64] == $past(wdCnt_r)) // RULE6
      else $error("debug reply malformed");
   a_txt_count: assert property (go && txtCmd |=> txtValid && txtCnt == 5'($past(cmdLen) - 5'h02)) // RULE8
      else $error("text count wrong");
   a_baud_hold: assert property (ce && baudPend_r && !rspSent && !(cmdValid && baudCmd)
      |=> $stable(baud_r) && baudPend_r) // RULE9
      else $error("baud switched before acknowledge sent");
   a_bad_no_ack: assert property (ce && cmdValid && !cmdOk |=> cmdErr && !rspValid && !txtValid) // RULE23
      else $error("refused command acknowledged");
   a_pin_index: assert property (ce && cmdValid && cmdType == 8'h22 && b0 >= 8'h05 |=> cmdErr) // RULE12
      else $error("reserved pin index accepted");
   a_pwm_full: assert property (gpVal_r[0] == 8'h64 |-> lvl[0]) // RULE14
      else $error("full duty not high");
   a_rst_release: assert property (ce && rstCnt_r == 32'h1 && !wdFire |=> !gpioOe[3] || gpCfg_r[3][3]) // RULE21
      else $error("reset pin not released");
   a_edge_set: assert property (ce && smpTick && s2_r[NPIN-1] && !smp_r[NPIN-1] |=> rise_r[NPIN-1]) // RULE19
      else $error("rising edge lost");

   c_wd_fire: cover property (ce && wdFire);
   c_baud_switch: cover property (ce && baudPend_r && rspSent);
   c_dbg_reply: cover property (go && dbgCmd);
   c_edge_read: cover property (go && rdCmd && rise_r[b0[2:0]]);
endmodule

// ===== dv/smc_host_link.sv
`timescale 1ns/10ps
module smc_host_link
#(
   parameter int DLY = 6
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // reply stream
   input wire logic rspValid,
   input wire logic [7:0] rspType,
   output logic rspSent,
   // host side rate, 1 = 19200
   output logic hostSlow
);
   int cnt;
   logic isBaud;
   // a reply takes DLY cycles on the wire, a newer reply restarts it
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt <= 0;
         isBaud <= 1'b0;
         rspSent <= 1'b0;
         hostSlow <= 1'b1;
      end
      else
      begin
         rspSent <= (cnt == 1);
         if (rspValid)
         begin
            cnt <= DLY;
            isBaud <= (rspType == 8'h61);
         end
         else if (cnt != 0)
            cnt <= cnt - 1;
         // switch only once the acknowledge is complete
         if (cnt == 1 && isBaud)
            hostSlow <= 1'b0;
      end
   end
endmodule

// ===== dv/smc_cmd_core_bench.sv
`timescale 1ns/10ps
module smc_cmd_core_bench;
   import smc_pkg::*;
   localparam int HR = 10;
   logic clk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, rstActLevel = 1'b0, ce = 1'b1;
   logic [7:0] cmdType = 8'h00;
   logic [4:0] cmdLen = 5'h00;
   logic [143:0] cmdData = '0;
   logic [95:0] stat = '0;
   logic [4:0] gpioIn = 5'h00, altOut = 5'h00, altOe = 5'h00;
   logic cmdErr, rspValid, rspSent, txtValid, txtRow, wdActive, hostRstAct, hostSlow;
   logic [7:0] rspType, baudCode;
   logic [3:0] rspLen, txtCol;
   logic [119:0] rspData;
   logic [4:0] txtCnt, gpioOut, gpioOe, gpioPu, gpioPd, gpioSlow;
   logic [127:0] txtData, ch, m;
   logic [31:0] seed = 32'h00013EFD;
   int num_errors = 0, total_checks = 0, n, k;
   always #10 clk = ~clk;
   smc_cmd_core #(.SEC_CYC(20), .HOSTRST_CYC(HR), .PWM_STEP_CYC(2), .SAMPLE_CYC(8)) i_smc_cmd_core (
      .clk(clk), .rst_b(rst_b), .ce(ce), .cmdValid(cmdValid), .cmdType(cmdType), .cmdLen(cmdLen),
      .cmdData(cmdData), .cmdErr(cmdErr), .rspValid(rspValid), .rspType(rspType), .rspLen(rspLen),
      .rspData(rspData), .rspSent(rspSent), .txtValid(txtValid), .txtCol(txtCol), .txtRow(txtRow),
      .txtCnt(txtCnt), .txtData(txtData), .baudCode(baudCode), .tempMask(stat[31:0]),
      .keyPressMask(stat[39:32]), .keyRelMask(stat[47:40]), .atxFunc(stat[55:48]), .contrast(stat[63:56]),
      .keyLight(stat[71:64]), .senseSel(stat[79:72]), .lcdContrast(stat[87:80]), .lcdLight(stat[95:88]),
      .rstActLevel(rstActLevel), .wdActive(wdActive), .hostRstAct(hostRstAct), .gpioIn(gpioIn),
      .altOut(altOut), .altOe(altOe), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioPu(gpioPu),
      .gpioPd(gpioPd), .gpioSlow(gpioSlow));
   smc_host_link #(.DLY(6)) i_smc_host_link (.clk(clk), .rst_b(rst_b), .rspValid(rspValid),
      .rspType(rspType), .rspSent(rspSent), .hostSlow(hostSlow));
   function automatic logic [31:0] lf(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   function automatic logic [119:0] dbgExp(input logic [95:0] s, input logic [7:0] w);
      return {s[95:80], 8'h00, s[79:56], w, s[55:0], 8'h00};
   endfunction
   function automatic logic [4:0] drvExp(input logic [2:0] md, input logic hi);
      // {drive enable, driven level, pull up, pull down, slow edge}
      case (md)
         3'h0: return hi ? 5'h18 : 5'h02;
         3'h1: return hi ? 5'h18 : 5'h10;
         3'h3: return hi ? 5'h04 : 5'h10;
         3'h4: return hi ? 5'h19 : 5'h00;
         3'h5: return hi ? 5'h19 : 5'h11;
         3'h7: return hi ? 5'h00 : 5'h11;
         default: return 5'h00;
      endcase
   endfunction
   function automatic logic [4:0] pinView(input int i);
      // level and slew only matter while the pin is driven
      return {gpioOe[i], gpioOut[i] & gpioOe[i], gpioPu[i], gpioPd[i], gpioSlow[i] & gpioOe[i]};
   endfunction
   task automatic test_done;
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [127:0] g, input logic [127:0] e, input string s);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("FAIL %0t %s", $time, s);
      end
   endtask
   task automatic chkRsp(input logic [7:0] t, input logic [3:0] l, input logic [119:0] d);
      total_checks++;
      if (rspType !== t || rspLen !== l || (l != 4'h0 && rspData[8*l-1-:8] !== d[8*l-1-:8])
         || (l == 4'hF && rspData !== d) || (l == 4'h4 && rspData[31:0] !== d[31:0]))
      begin
         num_errors++;
         $display("FAIL %0t reply %h", $time, rspType);
      end
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic send(input logic [7:0] t, input logic [4:0] l, input logic [143:0] d, input logic ok);
      @(posedge clk);
      cmdType <= t;
      cmdLen <= l;
      cmdData <= d;
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
      #1;
      chk({rspValid, cmdErr}, {ok, ~ok}, "accept or refuse");
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      step;
      chk({wdActive, hostRstAct, baudCode}, 10'h001, "reset state");
      rstActLevel <= seed[3];
      send(8'h1D, 5'h01, 144'h02, 1'b1);
      chkRsp(8'h5D, 4'h0, '0);
      chk(wdActive, 1'b1, "wd on");
      // ten frozen cycles push expiry ten cycles later
      @(posedge clk);
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      #1;
      for (n = 0; n < 60 && hostRstAct !== 1'b1; n++) step;
      chk(n >= 39 && n <= 41, 1'b1, "wd expiry time");
      chk({wdActive, gpioOe[3], gpioOut[3]}, {2'b01, rstActLevel}, "host reset drive");
      for (n = 0; n < 30 && hostRstAct === 1'b1; n++) step;
      chk(n, HR, "host reset length");
      chk(gpioOe[3], 1'b0, "reset pin released");
      repeat (100) step;
      chk(hostRstAct, 1'b0, "no second reset");
      send(8'h1D, 5'h01, 144'h03, 1'b1);
      send(8'h1E, 5'h00, '0, 1'b1);
      chkRsp(8'h5E, 4'hF, dbgExp(stat, 8'h03));
      repeat (50) step;
      send(8'h1D, 5'h01, 144'h03, 1'b1);
      repeat (50) step;
      chk({wdActive, hostRstAct}, 2'b10, "fed watchdog holds");
      send(8'h1D, 5'h01, 144'h00, 1'b1);
      repeat (100) step;
      chk({wdActive, hostRstAct}, 2'b00, "wd off");
      @(posedge clk);
      stat <= {seed, lf(seed), lf(lf(seed))};
      send(8'h1E, 5'h00, '0, 1'b1);
      chkRsp(8'h5E, 4'hF, dbgExp(stat, 8'h00));
      send(8'h1E, 5'h01, '0, 1'b0);
      for (k = 0; k < 6; k++)
      begin
         seed = lf(seed);
         ch = {lf(seed), lf(lf(seed)), seed, ~seed};
         n = (k == 0) ? 16 : ((k == 1) ? 1 : seed[8:5] + 1);
         m = (128'h1 << (8 * n)) - 1;
         send(8'h1F, n + 2, {ch, 7'h00, seed[4], 4'h0, seed[3:0]}, 1'b1);
         chk({txtValid, txtCol, txtRow, txtCnt}, {1'b1, seed[3:0], seed[4], n[4:0]}, "text pos");
         chk(txtData & m, ch & m, "text chars");
         chkRsp(8'h5F, 4'h0, '0);
      end
      send(8'h1F, 5'h03, 144'h41_00_10, 1'b0);
      send(8'h1F, 5'h03, 144'h41_02_00, 1'b0);
      send(8'h1F, 5'h02, 144'h00_00, 1'b0);
      send(8'h1F, 5'h13, 144'h00, 1'b0);
      chk(txtValid, 1'b0, "no text on refusal");
      send(8'h21, 5'h01, 144'h02, 1'b0);
      send(8'h21, 5'h01, 144'h00, 1'b1);
      chkRsp(8'h61, 4'h0, '0);
      chk(baudCode, 8'h01, "old rate during ack");
      for (n = 0; n < 30 && baudCode === 8'h01; n++) step;
      chk({baudCode, hostSlow}, 9'h000, "new rate after ack");
      send(8'h22, 5'h02, 144'h00_05, 1'b0);
      send(8'h23, 5'h01, 144'h05, 1'b0);
      send(8'h22, 5'h02, 144'h65_00, 1'b0);
      send(8'h22, 5'h03, 144'h10_00_00, 1'b0);
      send(8'h22, 5'h03, 144'h0E_00_00, 1'b0);
      send(8'h22, 5'h04, 144'h09_00_00, 1'b0);
      send(8'h23, 5'h01, 144'h00, 1'b1);
      chkRsp(8'h63, 4'h4, 120'h02_00_00_00);
      send(8'h22, 5'h03, 144'h09_64_00, 1'b1);
      chkRsp(8'h62, 4'h0, '0);
      chk({gpioOe[0], gpioOut[0]}, 2'b11, "drive high");
      send(8'h22, 5'h02, 144'h00_00, 1'b1);
      chk({gpioOe[0], gpioOut[0]}, 2'b10, "drive low");
      send(8'h23, 5'h01, 144'h00, 1'b1);
      chkRsp(8'h63, 4'h4, 120'h09_00_00_00);
      send(8'h22, 5'h02, 144'h1E_00, 1'b1);
      for (n = 0, k = 0; n < 200; n++)
      begin
         step;
         k += gpioOut[0];
      end
      chk(k, 60, "pwm duty");
      for (k = 0; k < 16; k++)
      begin
         if (k[3:1] != 3'h6)
         begin
            send(8'h22, 5'h03, {120'h0, 5'h01, k[3:1], (k[0] ? 8'h64 : 8'h00), 8'h00}, 1'b1);
            chk(pinView(0), drvExp(k[3:1], k[0]), "drive mode");
         end
      end
      @(posedge clk);
      altOut <= seed[4:0];
      altOe <= seed[9:5];
      step;
      chk({gpioOut[1], gpioOe[1]}, {altOut[1], altOe[1]}, "shared function");
      @(posedge clk);
      gpioIn[4] <= 1'b1;
      repeat (24) step;
      send(8'h23, 5'h01, 144'h04, 1'b1);
      chkRsp(8'h63, 4'h4, 120'h02_00_05_04);
      send(8'h23, 5'h01, 144'h04, 1'b1);
      chkRsp(8'h63, 4'h4, 120'h02_00_01_04);
      @(posedge clk);
      gpioIn[4] <= 1'b0;
      repeat (24) step;
      send(8'h23, 5'h01, 144'h04, 1'b1);
      chkRsp(8'h63, 4'h4, 120'h02_00_02_04);
      send(8'h30, 5'h00, '0, 1'b0);
      test_done;
   end
endmodule
